// ===== core/trc_device.sv
// What this block does
// - Mode select sampled on rising test clock
// - Data in shifts into selected register
// - Data out changes only on falling edges
// - Data out floats when nothing selected
// - Float transitions only after falling edge
// - Test reset low: reset state, float
// - Controller holds test reset low at power-up
// - Float and test reset low: outputs float
// - Scan input low selects internal scan
// - Master reset low resets registers after the two-flop sync delay
// - Master reset enables data-path resets, power-downs
// - System holds master reset during power-up
// - Pin A: fixed reference or adapter reference
// - Pin B: input, or adapter clock output
// - Adapter on, unselected clock pin driven low
// - Interrupt floats in reset, sources disabled
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module trc_device
  import trc_pkg::*;
(
  // System clock and synchronous reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Test and control pins
  trc_link_if.dev link,
  // Clock pins, adapter controls
  input wire logic adapter_enable_i,
  input wire logic [1:0] adapter_out_sel_i,
  input wire logic gen_clock_i,
  input wire logic ref_clock_pin_a_i,
  input wire logic ref_clock_pin_b_i,
  input wire logic ref_clock_pin_c_i,
  output logic ref_clock_pin_b_o,
  output logic ref_clock_pin_b_oe_n_o,
  output logic ref_clock_pin_c_o,
  output logic ref_clock_pin_c_oe_n_o,
  output logic adapter_ref_a_o,
  output logic fixed_ref_a_o,
  output logic fixed_ref_b_o,
  output logic fixed_ref_c_o,
  // Core state
  input wire logic irq_event_i,
  input wire logic irq_enable_wr_i,
  input wire logic irq_enable_i,
  output logic int_n_o,
  output logic int_oe_n_o,
  output logic scan_mode_o,
  output logic float_all_o,
  output logic global_dp_reset_o,
  output logic [3:0] port_dp_reset_o,
  output logic [3:0] port_power_down_o,
  output logic [1:0] ir_o
);
  // Synchronisers for pins from outside the clk_i domain
  logic [1:0] tck_s, tms_s, tdi_s, trst_s, flt_s, scan_s, mrst_s;
  logic tck_d;
  trc_state_type state, next_state;
  logic [1:0] ir, ir_sh;
  logic [TRC_ID_W-1:0] dr_sh;
  logic bypass_sh;
  logic tdo, tdo_en;
  logic tck_rise, tck_fall, trst_low, mrst_low;
  logic irq_en;

  // Two-flop synchronisers; first stage read only by second
  always_ff @(posedge clk_i) begin
    tck_s <= {tck_s[0], link.tap_clock};
    tms_s <= {tms_s[0], link.tap_mode_select};
    tdi_s <= {tdi_s[0], link.tap_data_in};
    trst_s <= {trst_s[0], link.tap_reset_n};
    flt_s <= {flt_s[0], link.output_float_n};
    scan_s <= {scan_s[0], link.scan_test_n};
    mrst_s <= {mrst_s[0], link.master_reset_n};
    tck_d <= tck_s[1];
  end

  assign tck_rise = tck_s[1] & ~tck_d;
  assign tck_fall = ~tck_s[1] & tck_d;
  assign trst_low = ~trst_s[1];
  assign mrst_low = ~mrst_s[1] | rst_i;

  // Next TAP state from mode select at the rising edge
  always_comb begin
    next_state = state;
    unique case (state)
      TRC_RESET: next_state = tms_s[1] ? TRC_RESET : TRC_IDLE;
      TRC_IDLE: next_state = tms_s[1] ? TRC_SEL_DR : TRC_IDLE;
      TRC_SEL_DR: next_state = tms_s[1] ? TRC_SEL_IR : TRC_CAP_DR;
      TRC_CAP_DR: next_state = tms_s[1] ? TRC_EXIT1_DR : TRC_SHIFT_DR;
      TRC_SHIFT_DR: next_state = tms_s[1] ? TRC_EXIT1_DR : TRC_SHIFT_DR;
      TRC_EXIT1_DR: next_state = tms_s[1] ? TRC_UPD_DR : TRC_PAUSE_DR;
      TRC_PAUSE_DR: next_state = tms_s[1] ? TRC_EXIT2_DR : TRC_PAUSE_DR;
      TRC_EXIT2_DR: next_state = tms_s[1] ? TRC_UPD_DR : TRC_SHIFT_DR;
      TRC_UPD_DR: next_state = tms_s[1] ? TRC_SEL_DR : TRC_IDLE;
      TRC_SEL_IR: next_state = tms_s[1] ? TRC_RESET : TRC_CAP_IR;
      TRC_CAP_IR: next_state = tms_s[1] ? TRC_EXIT1_IR : TRC_SHIFT_IR;
      TRC_SHIFT_IR: next_state = tms_s[1] ? TRC_EXIT1_IR : TRC_SHIFT_IR;
      TRC_EXIT1_IR: next_state = tms_s[1] ? TRC_UPD_IR : TRC_PAUSE_IR;
      TRC_PAUSE_IR: next_state = tms_s[1] ? TRC_EXIT2_IR : TRC_PAUSE_IR;
      TRC_EXIT2_IR: next_state = tms_s[1] ? TRC_UPD_IR : TRC_SHIFT_IR;
      TRC_UPD_IR: next_state = tms_s[1] ? TRC_SEL_DR : TRC_IDLE;
    endcase
  end

  // TAP state advances only on rising test clock
  always_ff @(posedge clk_i) begin
    if (rst_i || trst_low) begin
      state <= TRC_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // Instruction register: capture, shift, update
  always_ff @(posedge clk_i) begin
    if (rst_i || trst_low || state == TRC_RESET) begin
      ir <= TRC_IR_IDCODE;
      ir_sh <= TRC_IR_CAPTURE;
    end else if (tck_rise) begin
      if (state == TRC_CAP_IR) begin
        ir_sh <= TRC_IR_CAPTURE;
      end else if (state == TRC_SHIFT_IR) begin
        ir_sh <= {tdi_s[1], ir_sh[1]};
      end else if (state == TRC_UPD_IR) begin
        ir <= ir_sh;
      end
    end
  end

  // Data registers: identification word or one-bit bypass
  always_ff @(posedge clk_i) begin
    if (rst_i || trst_low) begin
      dr_sh <= '0;
      bypass_sh <= 1'b0;
    end else if (tck_rise) begin
      if (state == TRC_CAP_DR) begin
        dr_sh <= TRC_ID_WORD;
        bypass_sh <= 1'b0;
      end else if (state == TRC_SHIFT_DR) begin
        dr_sh <= {tdi_s[1], dr_sh[TRC_ID_W-1:1]};
        bypass_sh <= tdi_s[1];
      end
    end
  end

  // Data out and its enable move only at the falling test clock
  always_ff @(posedge clk_i) begin
    if (rst_i || trst_low) begin
      tdo <= 1'b0;
      tdo_en <= 1'b0;
    end else if (tck_fall) begin
      tdo_en <= (state == TRC_SHIFT_DR) ||
                (state == TRC_SHIFT_IR);
      if (state == TRC_SHIFT_IR) begin
        tdo <= ir_sh[0];
      end else if (ir == TRC_IR_IDCODE) begin
        tdo <= dr_sh[0];
      end else begin
        tdo <= bypass_sh;
      end
    end
  end

  // Float override also covers the data out pin
  assign link.tap_data_out_o = tdo;
  assign link.tap_data_out_oe_n = ~tdo_en | float_all_o;

  // Global float and scan mode; pins are treated as asynchronous levels
  assign float_all_o = ~flt_s[1] & trst_low;
  assign scan_mode_o = ~scan_s[1];
  assign ir_o = ir;

  // Data-path resets and power-downs come up enabled
  always_ff @(posedge clk_i) begin
    if (mrst_low) begin
      global_dp_reset_o <= 1'b1;
      port_dp_reset_o <= 4'hf;
      port_power_down_o <= 4'hf;
    end else begin
      global_dp_reset_o <= 1'b0;
      port_dp_reset_o <= 4'h0;
      port_power_down_o <= port_power_down_o;
    end
  end

  // Interrupt: sources disabled until software enables them
  always_ff @(posedge clk_i) begin
    if (mrst_low) begin
      irq_en <= 1'b0;
    end else if (irq_enable_wr_i) begin
      irq_en <= irq_enable_i;
    end
  end
  assign int_n_o = 1'b0;
  assign int_oe_n_o = mrst_low | float_all_o | ~(irq_en & irq_event_i);

  // Clock pins: fixed references or adapter references and outputs
  assign fixed_ref_a_o = ~adapter_enable_i & ref_clock_pin_a_i;
  assign adapter_ref_a_o = adapter_enable_i & ref_clock_pin_a_i;
  assign fixed_ref_b_o = ~adapter_enable_i & ref_clock_pin_b_i;
  assign fixed_ref_c_o = ~adapter_enable_i & ref_clock_pin_c_i;
  assign ref_clock_pin_b_o = adapter_out_sel_i[0] & gen_clock_i;
  assign ref_clock_pin_c_o = adapter_out_sel_i[1] & gen_clock_i;
  assign ref_clock_pin_b_oe_n_o = ~adapter_enable_i | float_all_o;
  assign ref_clock_pin_c_oe_n_o = ~adapter_enable_i | float_all_o;
endmodule

// ===== core/trc_pkg.sv
package trc_pkg;
  // TAP controller states, standard 16-state boundary-scan sequence
  typedef enum logic [3:0] {
    TRC_RESET      = 4'h0,
    TRC_IDLE       = 4'h1,
    TRC_SEL_DR     = 4'h2,
    TRC_CAP_DR     = 4'h3,
    TRC_SHIFT_DR   = 4'h4,
    TRC_EXIT1_DR   = 4'h5,
    TRC_PAUSE_DR   = 4'h6,
    TRC_EXIT2_DR   = 4'h7,
    TRC_UPD_DR     = 4'h8,
    TRC_SEL_IR     = 4'h9,
    TRC_CAP_IR     = 4'ha,
    TRC_SHIFT_IR   = 4'hb,
    TRC_EXIT1_IR   = 4'hc,
    TRC_PAUSE_IR   = 4'hd,
    TRC_EXIT2_IR   = 4'he,
    TRC_UPD_IR     = 4'hf
  } trc_state_type;

  // Instruction register
  localparam int TRC_IR_W = 2;
  localparam logic [1:0] TRC_IR_CAPTURE = 2'h1;
  localparam logic [1:0] TRC_IR_BYPASS = 2'h3;
  localparam logic [1:0] TRC_IR_IDCODE = 2'h2;
  // Identification word: arbitrary neutral value
  localparam logic [31:0] TRC_ID_WORD = 32'h0000_1001;
  localparam int TRC_ID_W = 32;

  // Clock rate adapter pin selection codes
  localparam logic [1:0] TRC_CLK_OUT_NONE = 2'h0;
  localparam logic [1:0] TRC_CLK_OUT_B = 2'h1;
  localparam logic [1:0] TRC_CLK_OUT_C = 2'h2;
  localparam logic [1:0] TRC_CLK_OUT_BC = 2'h3;

  // Test clock generated by the controller: half period in clk_i cycles
  localparam int TRC_TCK_PERIOD_NS = 80;
  localparam int TRC_CLK_PERIOD_NS = 10;
  localparam logic [7:0] TRC_TCK_HALF =
    8'((TRC_TCK_PERIOD_NS / TRC_CLK_PERIOD_NS) / 2);

  // Wishbone register offsets of the controller
  localparam logic [3:0] TRC_REG_CTRL = 4'h0;
  localparam logic [3:0] TRC_REG_SHIFT = 4'h4;
  localparam logic [3:0] TRC_REG_STATUS = 4'h8;
  localparam logic [3:0] TRC_REG_CAPT = 4'hc;
  // Control register field positions
  localparam int TRC_CTRL_TRST = 0;
  localparam int TRC_CTRL_FLOAT = 1;
  localparam int TRC_CTRL_SCAN = 2;
  localparam int TRC_CTRL_MRST = 3;
  localparam int TRC_CTRL_LEN_LSB = 8;
  // Control reset value: test reset, float, scan and master reset low
  localparam logic [31:0] TRC_CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] TRC_UNMAPPED = 8'hee;
endpackage

// ===== core/trc_link_if.sv
`timescale 1ns/1ps
interface trc_link_if;
  logic tap_clock;
  logic tap_mode_select;
  logic tap_data_in;
  logic tap_reset_n;
  logic tap_data_out_o;
  logic tap_data_out_oe_n;
  logic output_float_n;
  logic scan_test_n;
  logic master_reset_n;

  modport dev (
    input tap_clock, tap_mode_select, tap_data_in, tap_reset_n,
    input output_float_n, scan_test_n, master_reset_n,
    output tap_data_out_o, tap_data_out_oe_n
  );
  modport ctl (
    output tap_clock, tap_mode_select, tap_data_in, tap_reset_n,
    output output_float_n, scan_test_n, master_reset_n,
    input tap_data_out_o, tap_data_out_oe_n
  );
endinterface

// ===== core/trc_controller.sv
`timescale 1ns/1ps
module trc_controller
  import trc_pkg::*;
(
  // System clock and synchronous reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins toward the device
  trc_link_if.ctl link
);
  logic [31:0] ctrl, shift_out, capt;
  logic [5:0] bits_left;
  logic [7:0] div;
  logic tck, busy, go;
  logic [1:0] tdo_s, tdoen_s;

  // Test clock made from clk_i by a divider, runs only while busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 8'h00;
      tck <= 1'b0;
    end else if (busy) begin
      if (div == TRC_TCK_HALF - 8'h01) begin
        div <= 8'h00;
        tck <= ~tck;
      end else begin
        div <= div + 8'h01;
      end
    end else begin
      div <= 8'h00;
      tck <= 1'b0;
    end
  end

  // Read data from device, synchronised
  always_ff @(posedge clk_i) begin
    tdo_s <= {tdo_s[0], link.tap_data_out_o};
    tdoen_s <= {tdoen_s[0], link.tap_data_out_oe_n};
  end

  assign go = cyc_i & stb_i & we_i & ~ack_o & adr_i == TRC_REG_SHIFT;

  // Shift engine: each bit presents mode select and data before rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      bits_left <= 6'h00;
      shift_out <= 32'h0;
      capt <= 32'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      shift_out <= dat_i;
      bits_left <= ctrl[TRC_CTRL_LEN_LSB +: 6];
    end else if (busy && tck && div == TRC_TCK_HALF - 8'h01) begin
      // Falling edge: sample data out, move to next bit
      capt <= {tdo_s[1] & ~tdoen_s[1], capt[31:1]};
      shift_out <= {1'b0, shift_out[31:1]};
      if (bits_left == 6'h00) begin
        busy <= 1'b0;
      end else begin
        bits_left <= bits_left - 6'h01;
      end
    end
  end

  // Mode select in bit 0 of word, data in bit 16, both shifted right
  assign link.tap_clock = tck;
  assign link.tap_mode_select = shift_out[0];
  assign link.tap_data_in = shift_out[16];
  assign link.tap_reset_n = ctrl[TRC_CTRL_TRST];
  assign link.output_float_n = ctrl[TRC_CTRL_FLOAT];
  assign link.scan_test_n = ctrl[TRC_CTRL_SCAN];
  assign link.master_reset_n = ctrl[TRC_CTRL_MRST];

  // Control register writes; shift writes stall until engine idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= TRC_CTRL_RESET;
    end else if (cyc_i && stb_i && we_i && !ack_o &&
                 adr_i == TRC_REG_CTRL) begin
      if (sel_i[0]) ctrl[7:0] <= dat_i[7:0];
      if (sel_i[1]) ctrl[15:8] <= dat_i[15:8];
    end
  end

  // Acknowledge one cycle after request; shift write waits for idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o & ~(go & busy);
      unique case (adr_i)
        TRC_REG_CTRL: dat_o <= ctrl;
        TRC_REG_SHIFT: dat_o <= shift_out;
        TRC_REG_STATUS: dat_o <= {30'h0, ~tdoen_s[1], busy};
        TRC_REG_CAPT: dat_o <= capt;
        default: dat_o <= {24'h0, TRC_UNMAPPED};
      endcase
    end
  end
endmodule

// ===== verif/trc_link_monitor.sv
`timescale 1ns/1ps
module trc_link_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link pins
  input wire logic tap_clock,
  input wire logic tap_mode_select,
  input wire logic tap_data_in,
  input wire logic tap_reset_n,
  input wire logic tap_data_out_o,
  input wire logic tap_data_out_oe_n,
  input wire logic output_float_n,
  input wire logic scan_test_n,
  input wire logic master_reset_n
);
  logic tck_q;
  logic [2:0] ones;
  logic [3:0] hold;
  logic [3:0] quiet;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Five mode-select ones park the controller where nothing is selected
  always_ff @(posedge clk_i) begin
    tck_q <= tap_clock;
    if (rst_i || !tap_reset_n) begin
      ones <= 3'h5;
    end else if (tap_clock && !tck_q) begin
      ones <= !tap_mode_select ? 3'h0 : (ones == 3'h5 ? ones : ones + 3'h1);
    end
  end
  // Dwell counters; the sync chains make pin effects lag by some cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || ones != 3'h5) hold <= 4'h0;
    else if (hold != 4'hf) hold <= hold + 4'h1;
    if (rst_i || !(tap_reset_n && output_float_n && master_reset_n)) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  tdo_edge_a: assert property (
    ($changed(tap_data_out_o) && !tap_data_out_oe_n &&
     $past(!tap_data_out_oe_n))
    |-> !tap_clock) else $error("data out moved while test clock high");
  oe_edge_a: assert property (
    ($changed(tap_data_out_oe_n) && quiet > 4'h6) |-> !tap_clock)
    else $error("float change while test clock high");
  trst_float_a: assert property (
    (!tap_reset_n)[*4] |-> tap_data_out_oe_n)
    else $error("data out driven in test reset");
  hiz_float_a: assert property (
    (!tap_reset_n && !output_float_n)[*4] |-> tap_data_out_oe_n)
    else $error("data out driven in float mode");
  reset_float_a: assert property (
    @(posedge clk_i) disable iff (1'b0) rst_i[*3] |-> tap_data_out_oe_n)
    else $error("data out driven during reset");
  idle_float_a: assert property (
    hold == 4'hc |-> tap_data_out_oe_n)
    else $error("data out driven with nothing selected");
  pwr_hold_a: assert property (
    $fell(rst_i) |-> !tap_reset_n && !master_reset_n)
    else $error("resets not held low after power-up");
  tms_setup_a: assert property (
    $rose(tap_clock) |-> $stable(tap_mode_select) && $stable(tap_data_in))
    else $error("mode or data moved at test clock rise");
  cover property ($fell(tap_data_out_oe_n));
  cover property (hold == 4'hc);
  cover property ($fell(master_reset_n) && scan_test_n);
endmodule

// ===== verif/test_reset_and_clock_pin_ctrl_tb_top.sv
`timescale 1ns/1ps
module test_reset_and_clock_pin_ctrl_tb_top;
  import trc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] adr = 4'h0, cb = 4'h0, sel = 4'h0, pdr, ppd;
  logic [31:0] dat_w = 32'h0, dat_r, q;
  logic en = 1'b0, gen = 1'b0, pa = 1'b0, pb = 1'b0, pc = 1'b0;
  logic ev = 1'b0, ewr = 1'b0, eon = 1'b0;
  logic [1:0] osel = 2'h0, ir;
  logic bo, boe, co, coe, ara, fa, fb, fc, ioe, scan, flt, gdr, intn;
  int n_mismatch = 0, checks = 0;
  trc_link_if trc_link_if_i ();
  // 100 MHz system clock
  always #5 clk_i = ~clk_i;
  // Both ends face each other through the link
  trc_controller trc_controller_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .link(trc_link_if_i));
  trc_device trc_device_i (.clk_i(clk_i), .rst_i(rst_i),
    .link(trc_link_if_i), .adapter_enable_i(en), .adapter_out_sel_i(osel),
    .gen_clock_i(gen), .ref_clock_pin_a_i(pa), .ref_clock_pin_b_i(pb),
    .ref_clock_pin_c_i(pc), .ref_clock_pin_b_o(bo),
    .ref_clock_pin_b_oe_n_o(boe), .ref_clock_pin_c_o(co),
    .ref_clock_pin_c_oe_n_o(coe), .adapter_ref_a_o(ara),
    .fixed_ref_a_o(fa), .fixed_ref_b_o(fb), .fixed_ref_c_o(fc),
    .irq_event_i(ev), .irq_enable_wr_i(ewr), .irq_enable_i(eon),
    .int_n_o(intn), .int_oe_n_o(ioe), .scan_mode_o(scan),
    .float_all_o(flt), .global_dp_reset_o(gdr), .port_dp_reset_o(pdr),
    .port_power_down_o(ppd), .ir_o(ir));
  trc_link_monitor trc_link_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
    .tap_clock(trc_link_if_i.tap_clock),
    .tap_mode_select(trc_link_if_i.tap_mode_select),
    .tap_data_in(trc_link_if_i.tap_data_in),
    .tap_reset_n(trc_link_if_i.tap_reset_n),
    .tap_data_out_o(trc_link_if_i.tap_data_out_o),
    .tap_data_out_oe_n(trc_link_if_i.tap_data_out_oe_n),
    .output_float_n(trc_link_if_i.output_float_n),
    .scan_test_n(trc_link_if_i.scan_test_n),
    .master_reset_n(trc_link_if_i.master_reset_n));
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string m);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // A wait that runs out ends the run at once
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch %0t wait ran out", $time);
      stop_test();
    end
  endtask
  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dat_w <= d;
    for (int n = 0; n < 400; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    tmo(ack === 1'b1);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask
  // Run len+1 test clocks, then poll busy; slow because each is 8 cycles
  task automatic shift(input logic [15:0] tms, input logic [15:0] tdi,
    input logic [5:0] len);
    wb(1'b1, TRC_REG_CTRL, {18'h0, len, 4'h0, cb}, q);
    wb(1'b1, TRC_REG_SHIFT, {tdi, tms}, q);
    for (int n = 0; n < 100; n++) begin
      wb(1'b0, TRC_REG_STATUS, 32'h0, q);
      if (q[0] === 1'b0) break;
    end
    tmo(q[0] === 1'b0);
  endtask
  task automatic t_pins();
    logic [31:0] e;
    for (int i = 0; i < 16; i++) begin
      cb = 4'(i);
      wb(1'b1, TRC_REG_CTRL, {28'h0, cb}, q);
      repeat (6) @(posedge clk_i);
      e = 32'({~cb[2], ~cb[1] & ~cb[0]});
      chk(32'({scan, flt}), e, "scan float");
      if (!cb[3]) begin
        chk(32'({gdr, pdr, ppd, ioe}), 32'h3ff, "mrst");
      end
    end
  endtask
  // Pin levels and generated clock both toggle so every gate is exercised
  task automatic t_clk();
    logic [31:0] g, e;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      en <= i[2];
      osel <= i[1:0];
      gen <= i[3];
      pa <= ~i[3];
      pb <= ~i[3];
      pc <= ~i[3];
      @(posedge clk_i);
      if (i[2]) begin
        g = 32'({bo, boe, co, coe, ara, fa, fb, fc});
        e = 32'({i[0] & i[3], 1'b0, i[1] & i[3], 1'b0, ~i[3], 3'h0});
        chk(g, e, "adapter on");
      end else begin
        g = 32'({boe, coe, ara, fa, fb, fc});
        e = 32'({2'h3, 1'b0, {3{~i[3]}}});
        chk(g, e, "adapter off");
      end
    end
  endtask
  task automatic t_irq();
    cb = 4'hf;
    wb(1'b1, TRC_REG_CTRL, 32'hf, q);
    ev <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(ioe), 32'h1, "irq masked");
    eon <= 1'b1;
    ewr <= 1'b1;
    @(posedge clk_i);
    ewr <= 1'b0;
    for (int n = 0; n < 20 && ioe !== 1'b0; n++) @(posedge clk_i);
    tmo(ioe === 1'b0);
    chk(32'(intn), 32'h0, "irq level");
    wb(1'b1, TRC_REG_CTRL, 32'h7, q);
    repeat (6) @(posedge clk_i);
    chk(32'({ioe, gdr, pdr, ppd}), 32'h3ff, "mrst");
    wb(1'b1, TRC_REG_CTRL, 32'hf, q);
    repeat (6) @(posedge clk_i);
    chk(32'(ioe), 32'h1, "irq cleared");
    ev <= 1'b0;
  endtask
  task automatic t_tap();
    shift(16'h005f, 16'h0, 6'h8);
    chk(32'(ir), 32'(TRC_IR_IDCODE), "ir after reset");
    shift(16'h0, 16'h0, 6'hf);
    wb(1'b0, TRC_REG_CAPT, 32'h0, q);
    chk(32'(q[31:16]), 32'(TRC_ID_WORD[15:0]), "id word");
    wb(1'b0, TRC_REG_STATUS, 32'h0, q);
    chk(32'(q[1]), 32'h1, "out driven");
    shift(16'h001f, 16'h0, 6'h4);
    wb(1'b0, TRC_REG_STATUS, 32'h0, q);
    chk(32'(q[1]), 32'h0, "float in reset state");
    shift(16'h005f, 16'h0, 6'h8);
    cb = 4'he;
    wb(1'b1, TRC_REG_CTRL, 32'he, q);
    repeat (8) @(posedge clk_i);
    wb(1'b0, TRC_REG_STATUS, 32'h0, q);
    chk(32'(q[1]), 32'h0, "float on test reset");
    cb = 4'hf;
    shift(16'h00c6, 16'h0060, 6'h8);
    chk(32'(ir), 32'(TRC_IR_BYPASS), "ir bypass");
    // One-bit bypass: data out trails data in by one test clock
    shift(16'h0001, 16'h5a50, 6'hf);
    wb(1'b0, TRC_REG_CAPT, 32'h0, q);
    chk(32'(q[31:16]), 32'hb4a0, "bypass path");
  endtask
  // Main sequence; reset held for 16 cycles first
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_pins();
    t_clk();
    t_irq();
    t_tap();
    wb(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'(TRC_UNMAPPED), "unmapped read");
    stop_test();
  end
endmodule
